// [logic/lms_cfg.svh]
`ifndef LMS_CFG_SVH
`define LMS_CFG_SVH
// Operation
// - enable low or reset restores register defaults
// - swing and shaping programmable per lane
// - idle control low: outputs follow inputs
// - idle control float: automatic idle detection
// - idle control high: outputs forced idle
// - lane0 host output from picked port
// - lane1 host output from picked port
// - lane0 routes to picked port, other muted
// - lane1 routes to picked port, other muted
// - fan-out drives both ports per lane
// - straps replace slave address low bits
// - open straps read zero, base address
// - data stable while clock high
// - falling data, clock high, is start
// - rising data, clock high, is stop
// - bus idle after free time or high timeout
// - register writes and reads both supported
// - six swing registers select 600/800 mV
// - write: address, pointer, data, each acked
// - read: pointer, restart, address, data, nack
// - host leaves free time before start

// slave address: base with straps in the low bits
`define LMS_SLAVE_BASE      7'h50

// register offsets
`define LMS_REG_LANE_A_SWING 8'h17
`define LMS_REG_LANE_A_SHAPE 8'h18
`define LMS_REG_LANE_B_SWING 8'h25
`define LMS_REG_LANE_B_SHAPE 8'h26
`define LMS_REG_LANE_C_SWING 8'h2D
`define LMS_REG_LANE_C_SHAPE 8'h2E
`define LMS_REG_LANE_D_SWING 8'h34
`define LMS_REG_LANE_D_SHAPE 8'h35
`define LMS_REG_LANE_E_SWING 8'h3B
`define LMS_REG_LANE_E_SHAPE 8'h3C
`define LMS_REG_LANE_F_SWING 8'h42
`define LMS_REG_LANE_F_SHAPE 8'h43

// reset value and field encodings
`define LMS_REG_RESET       8'h00
`define LMS_RD_UNMAPPED     8'h00
`define LMS_SWING_SEL_MSB   2
`define LMS_SWING_800       3'h7
`define LMS_SHAPE_OK        8'h01

// timing
`define LMS_CLK_NS          50
`define LMS_TBUF_NS         4700
`define LMS_THIGH_MAX_NS    50000
`define LMS_TBUF_CYC        11'((`LMS_TBUF_NS + `LMS_CLK_NS - 1) / `LMS_CLK_NS)
`define LMS_THIGH_MAX_CYC   11'(`LMS_THIGH_MAX_NS / `LMS_CLK_NS)

`endif

// [logic/lms_pkg.sv]
`default_nettype none
package lms_pkg;
    typedef enum logic [2:0] {PH_ADDR, PH_PTR, PH_DATA, PH_READ, PH_IGNORE} lms_phase_t;
    typedef enum logic [1:0] {IDLE_PASS, IDLE_AUTO, IDLE_FORCE} lms_idle_mode_t;
endpackage
`default_nettype wire

// [logic/lms_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "lms_cfg.svh"
module lms_top
    import lms_pkg::*;
(
    // system clock and reset
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    // management bus
    input  wire logic       scl_clk,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // straps and enable
    input  wire logic       serial_mgmt_enable,
    input  wire logic [3:0] addr_strap,
    // routing controls
    input  wire logic       lane0_source_pick,
    input  wire logic       lane1_source_pick,
    input  wire logic       dual_output_enable,
    input  wire logic       idle_ctl_high,
    input  wire logic       idle_ctl_low,
    // lane inputs
    input  wire logic       host_in_lane0,
    input  wire logic       host_in_lane1,
    input  wire logic       port_a_in_lane0,
    input  wire logic       port_a_in_lane1,
    input  wire logic       port_b_in_lane0,
    input  wire logic       port_b_in_lane1,
    // input signal detect, high above threshold
    input  wire logic       host_det_lane0,
    input  wire logic       host_det_lane1,
    input  wire logic       port_a_det_lane0,
    input  wire logic       port_a_det_lane1,
    input  wire logic       port_b_det_lane0,
    input  wire logic       port_b_det_lane1,
    // lane outputs
    output logic            host_out_lane0,
    output logic            host_out_lane1,
    output logic            port_a_out_lane0,
    output logic            port_a_out_lane1,
    output logic            port_b_out_lane0,
    output logic            port_b_out_lane1,
    // electrical idle per output
    output logic            host_idle_lane0,
    output logic            host_idle_lane1,
    output logic            port_a_idle_lane0,
    output logic            port_a_idle_lane1,
    output logic            port_b_idle_lane0,
    output logic            port_b_idle_lane1,
    // driver settings, lanes a..f
    output logic [5:0]      lane_swing_800,
    output logic [5:0]      lane_shape_ok,
    // status
    output logic            bus_idle
);

    // ********************************
    // pin synchronisers
    // ********************************
    localparam int NPIN = 27;

    logic [NPIN-1:0] pin_meta;
    logic [NPIN-1:0] pin_s;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            pin_meta <= '0;
            pin_s    <= '0;
        end
        else
        begin
            pin_meta <= {scl_clk, sda_in, serial_mgmt_enable, addr_strap, lane0_source_pick,
                         lane1_source_pick, dual_output_enable, idle_ctl_high, idle_ctl_low,
                         host_in_lane0, host_in_lane1, port_a_in_lane0, port_a_in_lane1,
                         port_b_in_lane0, port_b_in_lane1, host_det_lane0, host_det_lane1,
                         port_a_det_lane0, port_a_det_lane1, port_b_det_lane0, port_b_det_lane1,
                         3'h0};
            pin_s    <= pin_meta;
        end
    end

    logic       scl_s;
    logic       sda_s;
    logic       en_s;
    logic [3:0] strap_s;
    logic [1:0] pick_s;
    logic       fan_s;
    logic       idle_hi_s;
    logic       idle_lo_s;
    logic [1:0] host_in_s;
    logic [1:0] a_in_s;
    logic [1:0] b_in_s;
    logic [1:0] host_det_s;
    logic [1:0] a_det_s;
    logic [1:0] b_det_s;

    assign {scl_s, sda_s, en_s, strap_s} = pin_s[26:20];
    assign pick_s     = {pin_s[18], pin_s[19]};
    assign {fan_s, idle_hi_s, idle_lo_s} = pin_s[17:15];
    assign host_in_s  = {pin_s[13], pin_s[14]};
    assign a_in_s     = {pin_s[11], pin_s[12]};
    assign b_in_s     = {pin_s[9], pin_s[10]};
    assign host_det_s = {pin_s[7], pin_s[8]};
    assign a_det_s    = {pin_s[5], pin_s[6]};
    assign b_det_s    = {pin_s[3], pin_s[4]};

    // ********************************
    // bus conditions and idle
    // ********************************
    logic        scl_p;
    logic        sda_p;
    logic        start_ev;
    logic        stop_ev;
    logic        stop_seen;
    logic [10:0] high_cnt;
    logic        rel_pending;
    logic        link_clear;
    logic        cfg_clear;
    logic [6:0]  slave_addr;

    assign start_ev = scl_s && scl_p && sda_p && !sda_s;
    assign stop_ev  = scl_s && scl_p && !sda_p && sda_s;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end
        else
        begin
            scl_p <= scl_s;
            sda_p <= sda_s;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            high_cnt  <= '0;
            stop_seen <= 1'b0;
            bus_idle  <= 1'b0;
        end
        else
        begin
            if (!(scl_s && sda_s))
                high_cnt <= '0;
            else if (high_cnt != 11'h7FF)
                high_cnt <= 11'(high_cnt + 11'h001);
            if (stop_ev)
                stop_seen <= 1'b1;
            else if (start_ev)
                stop_seen <= 1'b0;
            if (!(scl_s && sda_s))
                bus_idle <= 1'b0;
            else if ((stop_seen && high_cnt > `LMS_TBUF_CYC) || high_cnt > `LMS_THIGH_MAX_CYC)
                bus_idle <= 1'b1;
        end
    end

    // link side held in reset outside frames; released only while clock is low,
    // so the release never races a link clock edge
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || !en_s || stop_ev || start_ev)
        begin
            link_clear  <= 1'b1;
            rel_pending <= start_ev && en_s && !sys_rst;
        end
        else if (rel_pending && !scl_s)
        begin
            link_clear  <= 1'b0;
            rel_pending <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            cfg_clear  <= 1'b1;
            slave_addr <= `LMS_SLAVE_BASE;
        end
        else
        begin
            cfg_clear  <= !en_s;
            slave_addr <= `LMS_SLAVE_BASE | {3'h0, strap_s};
        end
    end

    // ********************************
    // link domain (bus clock)
    // ********************************
    lms_phase_t phase;
    logic [3:0] bit_cnt;
    logic [6:0] shift;
    logic       ack_due;
    logic [7:0] rx_byte;
    logic [7:0] req_ptr;
    logic [7:0] req_data;
    logic       req_wr;
    logic       req_tgl;
    logic       oe_r;
    logic [7:0] rd_byte;

    assign rx_byte = {shift, sda_in};

    always_ff @(posedge scl_clk or posedge link_clear)
    begin
        if (link_clear)
        begin
            phase   <= PH_ADDR;
            bit_cnt <= '0;
            shift   <= '0;
            ack_due <= 1'b0;
        end
        else if (bit_cnt == 4'h8)
        begin
            bit_cnt <= '0;
            ack_due <= 1'b0;
            if (phase == PH_READ && sda_in)
                phase <= PH_IGNORE;
        end
        else
        begin
            bit_cnt <= 4'(bit_cnt + 4'h1);
            shift   <= rx_byte[6:0];
            if (bit_cnt == 4'h7)
            begin
                unique case (phase)
                    PH_ADDR:
                    begin
                        if (rx_byte[7:1] == slave_addr)
                        begin
                            ack_due <= 1'b1;
                            phase   <= rx_byte[0] ? PH_READ : PH_PTR;
                        end
                        else
                            phase <= PH_IGNORE;
                    end
                    PH_PTR:
                    begin
                        ack_due <= 1'b1;
                        phase   <= PH_DATA;
                    end
                    PH_DATA:
                    begin
                        ack_due <= 1'b1;
                        phase   <= PH_IGNORE;
                    end
                    PH_READ, PH_IGNORE:
                    begin
                        ack_due <= 1'b0;
                    end
                endcase
            end
        end
    end

    // pointer survives a repeated start
    always_ff @(posedge scl_clk or posedge cfg_clear)
    begin
        if (cfg_clear)
        begin
            req_ptr  <= '0;
            req_data <= '0;
            req_wr   <= 1'b0;
            req_tgl  <= 1'b0;
        end
        else if (!link_clear && bit_cnt == 4'h7 && phase == PH_PTR)
        begin
            req_ptr <= rx_byte;
            req_wr  <= 1'b0;
            req_tgl <= !req_tgl;
        end
        else if (!link_clear && bit_cnt == 4'h7 && phase == PH_DATA)
        begin
            req_data <= rx_byte;
            req_wr   <= 1'b1;
            req_tgl  <= !req_tgl;
        end
    end

    // drive on falling edge so data is settled across the high phase
    always_ff @(negedge scl_clk or posedge link_clear)
    begin
        if (link_clear)
            oe_r <= 1'b0;
        else if (bit_cnt == 4'h8)
            oe_r <= ack_due;
        else if (phase == PH_READ)
            oe_r <= !rd_byte[3'(4'h7 - bit_cnt)];
        else
            oe_r <= 1'b0;
    end

    assign sda_oe  = oe_r;
    assign sda_out = 1'b0;

    // ********************************
    // register file
    // ********************************
    localparam int NREG = 12;
    localparam logic [7:0] REG_OFS [NREG] = '{
        `LMS_REG_LANE_A_SWING, `LMS_REG_LANE_A_SHAPE, `LMS_REG_LANE_B_SWING, `LMS_REG_LANE_B_SHAPE,
        `LMS_REG_LANE_C_SWING, `LMS_REG_LANE_C_SHAPE, `LMS_REG_LANE_D_SWING, `LMS_REG_LANE_D_SHAPE,
        `LMS_REG_LANE_E_SWING, `LMS_REG_LANE_E_SHAPE, `LMS_REG_LANE_F_SWING, `LMS_REG_LANE_F_SHAPE};

    logic [2:0] tgl_sync;
    logic       req_edge;
    logic [7:0] cap_ptr;
    logic [7:0] reg_q [NREG];
    logic [7:0] next_rd;

    // request words are held from the toggle until the next byte, many cycles away
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            tgl_sync <= '0;
        else
            tgl_sync <= {tgl_sync[1:0], req_tgl};
    end

    assign req_edge = tgl_sync[2] ^ tgl_sync[1];

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            cap_ptr <= '0;
        else if (req_edge)
            cap_ptr <= req_ptr;
    end

    for (genvar g = 0; g < NREG; g++)
    begin : g_reg
        always_ff @(posedge clk_sys)
        begin
            if (sys_rst || !en_s)
                reg_q[g] <= `LMS_REG_RESET;
            else if (req_edge && req_wr && req_ptr == REG_OFS[g])
                reg_q[g] <= req_data;
        end
    end

    always_comb
    begin
        next_rd = `LMS_RD_UNMAPPED;
        for (int i = 0; i < NREG; i++)
        begin
            if (cap_ptr == REG_OFS[i])
                next_rd = reg_q[i];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            rd_byte <= '0;
        else
            rd_byte <= next_rd;
    end

    for (genvar l = 0; l < 6; l++)
    begin : g_drv
        always_ff @(posedge clk_sys)
        begin
            if (sys_rst)
            begin
                lane_swing_800[l] <= 1'b0;
                lane_shape_ok[l]  <= 1'b0;
            end
            else
            begin
                lane_swing_800[l] <= reg_q[2*l][`LMS_SWING_SEL_MSB:0] == `LMS_SWING_800;
                lane_shape_ok[l]  <= reg_q[2*l+1] == `LMS_SHAPE_OK;
            end
        end
    end

    // ********************************
    // routing and idle control
    // ********************************
    lms_idle_mode_t idle_mode;
    logic [1:0]     h_data;
    logic [1:0]     h_idle;
    logic [1:0]     a_data;
    logic [1:0]     a_idle;
    logic [1:0]     b_data;
    logic [1:0]     b_idle;

    always_comb
    begin
        if (idle_hi_s)
            idle_mode = IDLE_FORCE;
        else if (idle_lo_s)
            idle_mode = IDLE_PASS;
        else
            idle_mode = IDLE_AUTO;
    end

    for (genvar k = 0; k < 2; k++)
    begin : g_lane
        logic src_det;
        logic a_mute;
        logic b_mute;
        assign src_det = pick_s[k] ? a_det_s[k] : b_det_s[k];
        assign a_mute  = !fan_s && !pick_s[k];
        assign b_mute  = !fan_s && pick_s[k];
        always_ff @(posedge clk_sys)
        begin
            if (sys_rst)
            begin
                h_data[k] <= 1'b0;
                h_idle[k] <= 1'b1;
                a_data[k] <= 1'b0;
                a_idle[k] <= 1'b1;
                b_data[k] <= 1'b0;
                b_idle[k] <= 1'b1;
            end
            else
            begin
                h_data[k] <= pick_s[k] ? a_in_s[k] : b_in_s[k];
                h_idle[k] <= idle_mode == IDLE_FORCE || (idle_mode == IDLE_AUTO && !src_det);
                a_data[k] <= host_in_s[k] && !a_mute;
                b_data[k] <= host_in_s[k] && !b_mute;
                a_idle[k] <= a_mute || idle_mode == IDLE_FORCE || (idle_mode == IDLE_AUTO && !host_det_s[k]);
                b_idle[k] <= b_mute || idle_mode == IDLE_FORCE || (idle_mode == IDLE_AUTO && !host_det_s[k]);
            end
        end
    end

    assign host_out_lane0    = h_data[0];
    assign host_out_lane1    = h_data[1];
    assign port_a_out_lane0  = a_data[0];
    assign port_a_out_lane1  = a_data[1];
    assign port_b_out_lane0  = b_data[0];
    assign port_b_out_lane1  = b_data[1];
    assign host_idle_lane0   = h_idle[0];
    assign host_idle_lane1   = h_idle[1];
    assign port_a_idle_lane0 = a_idle[0];
    assign port_a_idle_lane1 = a_idle[1];
    assign port_b_idle_lane0 = b_idle[0];
    assign port_b_idle_lane1 = b_idle[1];

endmodule
`default_nettype wire

// [verification/lms_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module lms_chk
    import lms_pkg::*;
(
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    // bus and controls
    input wire logic       scl_clk,
    input wire logic       sda_in,
    input wire logic       serial_mgmt_enable,
    input wire logic       lane0_source_pick,
    input wire logic       dual_output_enable,
    input wire logic       idle_ctl_high,
    input wire logic       idle_ctl_low,
    // lane 0 view, plus shape flags and bus idle
    input wire logic       host_in_lane0,
    input wire logic       port_a_in_lane0,
    input wire logic       port_b_in_lane0,
    input wire logic       host_det_lane0,
    input wire logic       host_out_lane0,
    input wire logic       port_a_out_lane0,
    input wire logic       port_b_out_lane0,
    input wire logic       port_a_idle_lane0,
    input wire logic       port_b_idle_lane0,
    input wire logic [5:0] lane_shape_ok,
    input wire logic       bus_idle
);
    // ****
    // helper counters
    // ****
    logic [2:0]  up_cnt;
    logic [10:0] hi_cnt;
    logic        up_ok;
    // pin views older than the sync pipe are meaningless right after reset
    assign up_ok = (up_cnt == 3'h7);
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            up_cnt <= 3'h0;
        else if (!up_ok)
            up_cnt <= up_cnt + 3'h1;
    end
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || !(scl_clk && sda_in))
            hi_cnt <= 11'h000;
        else if (hi_cnt != 11'h7FF)
            hi_cnt <= hi_cnt + 11'h001;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence en_low_s;
        !serial_mgmt_enable [*8];
    endsequence
    sequence fan_on_s;
        up_ok && $past(dual_output_enable, 3) && !$past(idle_ctl_high, 3);
    endsequence
    // ****
    // assertions
    // ****
    host_path_a: assert property (up_ok && !$past(idle_ctl_high, 3) |-> host_out_lane0 ==
        ($past(lane0_source_pick, 3) ? $past(port_a_in_lane0, 3) : $past(port_b_in_lane0, 3)))
        else $error("host lane0 path wrong");
    mute_b_a: assert property (up_ok && !$past(dual_output_enable, 3) && $past(lane0_source_pick, 3)
        |-> !port_b_out_lane0 && port_b_idle_lane0) else $error("port b lane0 not muted");
    fan_out_a: assert property (fan_on_s |-> port_a_out_lane0 == $past(host_in_lane0, 3)
        && port_b_out_lane0 == $past(host_in_lane0, 3)) else $error("fan-out path wrong");
    force_idle_a: assert property (up_ok && $past(idle_ctl_high, 3)
        |-> port_a_idle_lane0 && port_b_idle_lane0) else $error("forced idle missing");
    auto_idle_a: assert property (fan_on_s and !$past(idle_ctl_low, 3)
        |-> port_a_idle_lane0 == !$past(host_det_lane0, 3)) else $error("auto idle wrong");
    pass_idle_a: assert property (fan_on_s and $past(idle_ctl_low, 3) |-> !port_a_idle_lane0)
        else $error("pass mode shows idle");
    en_reset_a: assert property (en_low_s |-> lane_shape_ok == 6'h00)
        else $error("registers kept while disabled");
    bus_free_a: assert property (hi_cnt >= 11'h3F2 |-> bus_idle)
        else $error("bus idle not reported");
endmodule
bind lms_top lms_chk u_chk
(
    .clk_sys(clk_sys), .sys_rst(sys_rst), .scl_clk(scl_clk), .sda_in(sda_in),
    .serial_mgmt_enable(serial_mgmt_enable), .lane0_source_pick(lane0_source_pick),
    .dual_output_enable(dual_output_enable), .idle_ctl_high(idle_ctl_high), .idle_ctl_low(idle_ctl_low),
    .host_in_lane0(host_in_lane0), .port_a_in_lane0(port_a_in_lane0), .port_b_in_lane0(port_b_in_lane0),
    .host_det_lane0(host_det_lane0), .host_out_lane0(host_out_lane0), .port_a_out_lane0(port_a_out_lane0),
    .port_b_out_lane0(port_b_out_lane0), .port_a_idle_lane0(port_a_idle_lane0),
    .port_b_idle_lane0(port_b_idle_lane0), .lane_shape_ok(lane_shape_ok), .bus_idle(bus_idle)
);
`default_nettype wire

// [verification/lms_host_bfm.sv]
`timescale 1ns/100ps
`default_nettype none
module lms_host_bfm
(
    // link timebase
    input  wire logic lnk_clk,
    // bus wires
    output logic      scl_clk,
    output logic      host_pull,
    input  wire logic sda_in
);
    // high phase of the bus clock in link ticks; the low phase is 4 ticks longer
    localparam int PH = 42;
    initial
    begin
        scl_clk = 1'b1;
        host_pull = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge lnk_clk);
    endtask
    // data moves only a few ticks after the clock falls
    task automatic bit_io(input logic b, output logic r);
        tick(4);
        host_pull <= !b;
        tick(PH);
        scl_clk <= 1'b1;
        tick(PH);
        r = sda_in;
        scl_clk <= 1'b0;
    endtask
    task automatic start_c();
        tick(4);
        host_pull <= 1'b0;
        tick(PH);
        scl_clk <= 1'b1;
        tick(PH);
        host_pull <= 1'b1;
        tick(PH);
        scl_clk <= 1'b0;
    endtask
    task automatic stop_c();
        tick(4);
        host_pull <= 1'b1;
        tick(PH);
        scl_clk <= 1'b1;
        tick(PH);
        host_pull <= 1'b0;
        tick(400);
    endtask
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ak);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(a, ak);
    endtask
    task automatic reg_wr(input logic [6:0] sa, input logic [7:0] ra, input logic [7:0] d, output logic [2:0] ak);
        logic [7:0] q;
        start_c();
        xfer({sa, 1'b0}, 1'b1, q, ak[2]);
        xfer(ra, 1'b1, q, ak[1]);
        xfer(d, 1'b1, q, ak[0]);
        stop_c();
    endtask
    task automatic reg_rd(input logic [6:0] sa, input logic [7:0] ra, output logic [7:0] d, output logic [2:0] ak);
        logic nk;
        start_c();
        xfer({sa, 1'b0}, 1'b1, d, ak[2]);
        xfer(ra, 1'b1, d, ak[1]);
        start_c();
        xfer({sa, 1'b1}, 1'b1, d, ak[0]);
        xfer(8'hFF, 1'b1, d, nk);
        stop_c();
    endtask
endmodule
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic       clk_sys, lnk_clk, sys_rst, scl_clk, host_pull, sda_w, sda_out, sda_oe, det;
    logic       serial_mgmt_enable, lane0_source_pick, lane1_source_pick, dual_output_enable;
    logic       idle_ctl_high, idle_ctl_low, host_in_lane0, host_in_lane1;
    logic       port_a_in_lane0, port_a_in_lane1, port_b_in_lane0, port_b_in_lane1;
    logic       host_out_lane0, host_out_lane1, port_a_out_lane0, port_a_out_lane1;
    logic       port_b_out_lane0, port_b_out_lane1, port_a_idle_lane0, bus_idle;
    logic       host_idle_lane0, host_idle_lane1, port_a_idle_lane1, port_b_idle_lane0, port_b_idle_lane1;
    logic [3:0] addr_strap;
    logic [5:0] lane_swing_800, lane_shape_ok;
    int         fail_count = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    // open-drain data line with pull-up
    assign sda_w = !((sda_oe && !sda_out) || host_pull);
    lms_top dut
    (
        .clk_sys, .sys_rst, .scl_clk, .sda_in(sda_w), .sda_out, .sda_oe, .serial_mgmt_enable, .addr_strap,
        .lane0_source_pick, .lane1_source_pick, .dual_output_enable, .idle_ctl_high, .idle_ctl_low,
        .host_in_lane0, .host_in_lane1, .port_a_in_lane0, .port_a_in_lane1, .port_b_in_lane0, .port_b_in_lane1,
        .host_det_lane0(det), .host_det_lane1(det), .port_a_det_lane0(det), .port_a_det_lane1(det),
        .port_b_det_lane0(det), .port_b_det_lane1(det), .host_out_lane0, .host_out_lane1,
        .port_a_out_lane0, .port_a_out_lane1, .port_b_out_lane0, .port_b_out_lane1,
        .host_idle_lane0, .host_idle_lane1, .port_a_idle_lane0, .port_a_idle_lane1,
        .port_b_idle_lane0, .port_b_idle_lane1, .lane_swing_800, .lane_shape_ok, .bus_idle
    );
    lms_host_bfm host
    (
        .lnk_clk, .scl_clk, .host_pull, .sda_in(sda_w)
    );
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial
    begin
        lnk_clk = 1'b0;
        #3.3;
        forever #6 lnk_clk = ~lnk_clk;
    end
    // ****
    // checks and verdict
    // ****
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_sim();
        if (fail_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            fail_count++;
            end_sim();
        end
    end
    // ****
    // scenarios
    // ****
    task automatic t_route();
        logic [2:0] m;
        for (int i = 0; i < 8; i++)
        begin
            m = 3'(i);
            @(posedge clk_sys);
            {dual_output_enable, lane0_source_pick, lane1_source_pick} <= m;
            {host_in_lane0, host_in_lane1, port_a_in_lane0, port_b_in_lane1} <= 4'hF;
            repeat (5) @(posedge clk_sys);
            #1;
            chk("host0", m[1], host_out_lane0);
            chk("host1", !m[0], host_out_lane1);
            chk("a0", m[2] | m[1], port_a_out_lane0);
            chk("b0", m[2] | !m[1], port_b_out_lane0);
            chk("a1", m[2] | m[0], port_a_out_lane1);
            chk("b1", m[2] | !m[0], port_b_out_lane1);
            chk("idle1", {!(m[2] | m[0]), !(m[2] | !m[0])}, {port_a_idle_lane1, port_b_idle_lane1});
        end
    endtask
    task automatic t_idle();
        logic [3:0] v [4] = '{4'hB, 4'h1, 4'h2, 4'h4};
        foreach (v[i])
        begin
            @(posedge clk_sys);
            {idle_ctl_high, idle_ctl_low, det} <= v[i][3:1];
            repeat (5) @(posedge clk_sys);
            #1;
            chk("idle_a0", v[i][0], port_a_idle_lane0);
            chk("idle_h", {2{v[i][0]}}, {host_idle_lane0, host_idle_lane1});
            chk("idle_p", {3{v[i][0]}}, {port_a_idle_lane1, port_b_idle_lane0, port_b_idle_lane1});
        end
    endtask
    task automatic t_regs();
        logic [2:0] ak;
        logic [7:0] d;
        logic [7:0] sh [6] = '{8'h18, 8'h26, 8'h2E, 8'h35, 8'h3C, 8'h43};
        host.reg_rd(7'h50, 8'h18, d, ak);
        chk("reset_val", 8'h00, d);
        chk("rd_ack", 8'h00, ak);
        chk("sda_out", 8'h00, sda_out);
        foreach (sh[i])
        begin
            host.reg_wr(7'h50, sh[i], 8'h01, ak);
            chk("wr_ack", 8'h00, ak);
        end
        chk("shape_ok", 8'h3F, lane_shape_ok);
        host.reg_wr(7'h50, 8'h42, 8'h07, ak);
        host.reg_rd(7'h50, 8'h42, d, ak);
        chk("swing", 8'h07, d);
        chk("swing800", 8'h20, lane_swing_800);
        host.reg_rd(7'h50, 8'h01, d, ak);
        chk("unmapped", 8'h00, d);
        @(posedge clk_sys);
        addr_strap <= 4'h5;
        repeat (4) @(posedge clk_sys);
        host.reg_wr(7'h50, 8'h18, 8'h00, ak);
        chk("foreign_ack", 8'h07, ak);
        chk("foreign_wr", 8'h3F, lane_shape_ok);
        host.reg_wr(7'h55, 8'h18, 8'h00, ak);
        chk("strap_ack", 8'h00, ak);
        chk("strap_wr", 8'h3E, lane_shape_ok);
    endtask
    task automatic t_enable();
        logic [2:0] ak;
        logic [7:0] d;
        @(posedge clk_sys);
        addr_strap <= 4'h0;
        serial_mgmt_enable <= 1'b0;
        repeat (10) @(posedge clk_sys);
        serial_mgmt_enable <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        chk("en_shape", 8'h00, lane_shape_ok);
        host.reg_rd(7'h50, 8'h42, d, ak);
        chk("en_swing", 8'h00, d);
        repeat (1100) @(posedge clk_sys);
        #1;
        chk("bus_idle", 8'h01, bus_idle);
    endtask
    initial
    begin
        sys_rst = 1'b1;
        serial_mgmt_enable = 1'b1;
        addr_strap = 4'h0;
        {lane0_source_pick, lane1_source_pick, dual_output_enable, idle_ctl_high, idle_ctl_low, det} = 6'h01;
        {host_in_lane0, host_in_lane1, port_a_in_lane0, port_a_in_lane1, port_b_in_lane0, port_b_in_lane1} = 6'h00;
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        t_route();
        t_idle();
        t_regs();
        t_enable();
        end_sim();
    end
endmodule
`default_nettype wire
